/* File: rtl/hpsr_status.sv */
// hub port status reporting top
//
// Behaviour
// - local power change sets hub change bit 0.
// - hub over-current change sets hub change bit 1.
// - bus reset clears both hub change bits.
// - set hub feature on change bits is accepted for diagnostics.
// - clear hub feature clears the named change bit.
// - setting set or clearing clear feature is a no-operation.
// - hub status bits follow hardware only, never requests.
// - port error count request returns two-byte link error count.
// - error counters clear at power up and hub reset.
// - bad port, value or length gives a request error on port requests; hub feature requests check the value only.
// - port status request returns status word then change word.
// - change word bits line up with status word bits.
// - status bit 0 shows device presence.
// - status bit 1 shows port enabled; cleared when the port state is disabled or i_port_enabled is low.
// - status bit 3 shows per-port over-current.
// - status bit 4 set on reset request until signalling ends.
// - bits 5 to 8 carry link state code 0 to 0xb.
// - link state updates only after transition completes.
// - hub status bit 0 is power lost, bit 1 over-current.
// - connection bit only in enabled, resetting or error states.
`timescale 1ns/1ns
`default_nettype none
module hpsr_status #(
  parameter int NPORTS = 4,
  parameter int CW = 16,
  parameter bit PER_PORT_OC = 1'b1,
  parameter bit DIAG_SET = 1'b1
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_bus_reset,
  // control request
  input wire logic i_req_valid,
  input wire hpsr_pkg::hpsr_setup_t i_setup,
  output hpsr_pkg::hpsr_reply_t o_reply,
  // hub hardware conditions
  input wire logic i_local_power_lost,
  input wire logic i_hub_over_current,
  output logic [15:0] o_hub_status,
  output logic [15:0] o_hub_change,
  // per-port hardware conditions
  input wire hpsr_pkg::hpsr_dsport_t [NPORTS-1:0] i_ds_state,
  input wire logic [NPORTS-1:0] i_port_enabled,
  input wire logic [NPORTS-1:0] i_port_over_current,
  input wire logic [NPORTS-1:0] i_port_reset_req,
  input wire logic [NPORTS-1:0] i_port_reset_done,
  input wire logic [NPORTS-1:0] i_link_err,
  input wire logic [NPORTS-1:0] i_link_done,
  input wire logic [NPORTS*4-1:0] i_link_state,
  input wire logic [NPORTS*16-1:0] i_port_change
);
  import hpsr_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic lp_q;
    logic oc_q;
    logic [1:0] hchg;
    logic [NPORTS-1:0] rst_act;
    hpsr_reply_t rep;
  } hpsr_state_t;

  hpsr_state_t st_r, st_nxt;
  logic [CW-1:0] err_cnt [NPORTS];
  logic [3:0] ls [NPORTS];
  logic [15:0] psw [NPORTS];

  function automatic logic port_ok(input logic [15:0] idx);
    port_ok = (idx != 16'h0000) && (idx <= 16'(NPORTS));
  endfunction

  function automatic int port_sel(input logic [15:0] idx);
    port_sel = port_ok(idx) ? int'(idx) - 1 : 0;
  endfunction

  // ==========================================================
  // per-port trackers
  for (genvar g = 0; g < NPORTS; g++) begin : g_port
    hpsr_port_track #(.CW(CW)) u_trk (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_clr(i_bus_reset),
      .i_link_err(i_link_err[g]),
      .i_link_done(i_link_done[g]),
      .i_link_state(i_link_state[g*4 +: 4]),
      .o_err_cnt(err_cnt[g]),
      .o_link_state(ls[g])
    );
    // status word, reserved bits zero
    always_comb begin
      psw[g] = 16'h0000;
      psw[g][PS_CONNECT_BIT] = (i_ds_state[g] == DS_ENABLED) ||
        (i_ds_state[g] == DS_RESETTING) || (i_ds_state[g] == DS_ERROR);
      psw[g][PS_ENABLE_BIT] = i_port_enabled[g] && (i_ds_state[g] != DS_DISABLED);
      psw[g][PS_OVER_CURRENT_BIT] = PER_PORT_OC && i_port_over_current[g];
      psw[g][PS_RESET_BIT] = st_r.rst_act[g];
      psw[g][PS_LINK_HI:PS_LINK_LO] = ls[g];
    end
  end

  // ==========================================================
  // request handling and hub change tracking
  always_comb begin
    logic [15:0] v;
    logic is_clr;
    logic is_set;
    int p;
    v = 16'h0000;
    p = port_sel(i_setup.index);
    is_clr = i_req_valid && i_setup.req_type == RT_HUB_CLR &&
      i_setup.request == RQ_CLR_FEATURE;
    is_set = i_req_valid && i_setup.req_type == RT_HUB_SET &&
      i_setup.request == RQ_SET_FEATURE;
    st_nxt = st_r;
    st_nxt.rep.done = 1'b0;
    st_nxt.rep.req_err = 1'b0;
    // status bits follow hardware only
    st_nxt.lp_q = i_local_power_lost;
    st_nxt.oc_q = i_hub_over_current;
    // clears first so a same-cycle change wins
    if (is_clr && i_setup.value == FS_C_LOCAL_POWER) begin
      st_nxt.hchg[HC_LOCAL_POWER_BIT] = 1'b0;
    end
    if (is_clr && i_setup.value == FS_C_OVER_CURRENT) begin
      st_nxt.hchg[HC_OVER_CURRENT_BIT] = 1'b0;
    end
    if (is_set && DIAG_SET && i_setup.value == FS_C_LOCAL_POWER) begin
      st_nxt.hchg[HC_LOCAL_POWER_BIT] = 1'b1;
    end
    if (is_set && DIAG_SET && i_setup.value == FS_C_OVER_CURRENT) begin
      st_nxt.hchg[HC_OVER_CURRENT_BIT] = 1'b1;
    end
    if (st_r.lp_q != i_local_power_lost) begin
      st_nxt.hchg[HC_LOCAL_POWER_BIT] = 1'b1;
    end
    if (st_r.oc_q != i_hub_over_current) begin
      st_nxt.hchg[HC_OVER_CURRENT_BIT] = 1'b1;
    end
    if (is_clr || is_set) begin
      st_nxt.rep.done = 1'b1;
      st_nxt.rep.req_err = (i_setup.value != FS_C_LOCAL_POWER) &&
        (i_setup.value != FS_C_OVER_CURRENT);
      st_nxt.rep.word0 = 16'h0000;
      st_nxt.rep.word1 = 16'h0000;
    end
    // port reset indication
    for (int i = 0; i < NPORTS; i++) begin
      if (i_port_reset_req[i]) begin
        st_nxt.rst_act[i] = 1'b1;
      end else if (i_port_reset_done[i]) begin
        st_nxt.rst_act[i] = 1'b0;
      end
    end
    // error count request
    if (i_req_valid && i_setup.req_type == RT_PORT_ERR &&
        i_setup.request == RQ_GET_ERR_CNT) begin
      st_nxt.rep.done = 1'b1;
      st_nxt.rep.req_err = !port_ok(i_setup.index) || i_setup.value != 16'h0000 ||
        i_setup.length != LEN_ERR_CNT;
      v = 16'(err_cnt[p]);
      st_nxt.rep.word0 = st_nxt.rep.req_err ? 16'h0000 : v;
      st_nxt.rep.word1 = 16'h0000;
    end
    // port status request
    if (i_req_valid && i_setup.req_type == RT_PORT_STS &&
        i_setup.request == RQ_GET_STATUS) begin
      st_nxt.rep.done = 1'b1;
      st_nxt.rep.req_err = !port_ok(i_setup.index) || i_setup.value != 16'h0000 ||
        i_setup.length != LEN_PORT_STS;
      // status word first, then change word
      st_nxt.rep.word0 = st_nxt.rep.req_err ? 16'h0000 : psw[p];
      st_nxt.rep.word1 = st_nxt.rep.req_err ? 16'h0000 : i_port_change[p*16 +: 16];
    end
    if (i_bus_reset) begin
      st_nxt.hchg = 2'b00;
      st_nxt.rst_act = '0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_r <= '0;
      st_r.hchg <= HUB_CHANGE_RST[1:0];
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs, reserved bits zero
  assign o_reply = st_r.rep;
  assign o_hub_status = {14'h0000, st_r.oc_q, st_r.lp_q};
  assign o_hub_change = {14'h0000, st_r.hchg};
endmodule
`default_nettype wire

/* File: shared/hpsr_pkg.sv */
// package for hub port status reporting block
package hpsr_pkg;
  // request codes
  localparam logic [7:0] RT_PORT_ERR = 8'h80;
  localparam logic [7:0] RT_PORT_STS = 8'ha3;
  localparam logic [7:0] RT_HUB_CLR = 8'h20;
  localparam logic [7:0] RT_HUB_SET = 8'h20;
  localparam logic [7:0] RQ_GET_STATUS = 8'h00;
  localparam logic [7:0] RQ_CLR_FEATURE = 8'h01;
  localparam logic [7:0] RQ_SET_FEATURE = 8'h03;
  localparam logic [7:0] RQ_GET_ERR_CNT = 8'h1d;
  // hub feature selectors
  localparam logic [15:0] FS_C_LOCAL_POWER = 16'h0000;
  localparam logic [15:0] FS_C_OVER_CURRENT = 16'h0001;
  // lengths
  localparam logic [15:0] LEN_ERR_CNT = 16'h0002;
  localparam logic [15:0] LEN_PORT_STS = 16'h0004;
  // field positions
  localparam int HC_LOCAL_POWER_BIT = 0;
  localparam int HC_OVER_CURRENT_BIT = 1;
  localparam int PS_CONNECT_BIT = 0;
  localparam int PS_ENABLE_BIT = 1;
  localparam int PS_OVER_CURRENT_BIT = 3;
  localparam int PS_RESET_BIT = 4;
  localparam int PS_LINK_LO = 5;
  localparam int PS_LINK_HI = 8;
  // reset values
  localparam logic [15:0] HUB_CHANGE_RST = 16'h0000;
  localparam logic [15:0] ERR_CNT_RST = 16'h0000;
  // link state codes
  localparam logic [3:0] LS_MAX_VALID = 4'hb;
  // downstream port states
  typedef enum logic [4:0] {
    DS_OTHER = 5'h01,
    DS_ENABLED = 5'h02,
    DS_RESETTING = 5'h04,
    DS_ERROR = 5'h08,
    DS_DISABLED = 5'h10
  } hpsr_dsport_t;
  // setup packet
  typedef struct packed {
    logic [7:0] req_type;
    logic [7:0] request;
    logic [15:0] value;
    logic [15:0] index;
    logic [15:0] length;
  } hpsr_setup_t;
  // reply
  typedef struct packed {
    logic done;
    logic req_err;
    logic [15:0] word0;
    logic [15:0] word1;
  } hpsr_reply_t;
endpackage

/* File: rtl/hpsr_port_track.sv */
// per-port link error counter and link state holder
`timescale 1ns/1ns
`default_nettype none
module hpsr_port_track #(
  parameter int CW = 16
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // hub reset
  input wire logic i_clr,
  // link events
  input wire logic i_link_err,
  input wire logic i_link_done,
  input wire logic [3:0] i_link_state,
  // outputs
  output logic [CW-1:0] o_err_cnt,
  output logic [3:0] o_link_state
);
  import hpsr_pkg::*;
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [3:0] ls;
  } hpsr_trk_t;
  hpsr_trk_t st_r, st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (i_clr) begin
      st_nxt.cnt = CW'(ERR_CNT_RST);
    end else if (i_link_err && st_r.cnt != {CW{1'b1}}) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
    // latch only completed transitions to valid codes
    if (i_link_done && i_link_state <= LS_MAX_VALID) begin
      st_nxt.ls = i_link_state;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign o_err_cnt = st_r.cnt;
  assign o_link_state = st_r.ls;
endmodule
`default_nettype wire

/* File: tb/hpsr_status_asserts.sv */
// assertions for the hub port status block
`timescale 1ns/1ns
`default_nettype none
module hpsr_status_asserts (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_bus_reset,
  // request and reply
  input wire logic i_req_valid,
  input wire hpsr_pkg::hpsr_setup_t i_setup,
  input wire hpsr_pkg::hpsr_reply_t o_reply,
  // hub conditions
  input wire logic i_local_power_lost,
  input wire logic i_hub_over_current,
  input wire logic [15:0] o_hub_status,
  input wire logic [15:0] o_hub_change
);
  import hpsr_pkg::*;
  logic lp_chg;
  logic oc_chg;
  assign lp_chg = !i_bus_reset && (i_local_power_lost != o_hub_status[0]);
  assign oc_chg = !i_bus_reset && (i_hub_over_current != o_hub_status[1]);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================
  // checks
  lp_change_set_a: assert property (lp_chg |=> o_hub_change[0])
    else $error("power change flag not set");
  oc_change_set_a: assert property (oc_chg |=> o_hub_change[1])
    else $error("over-current change flag not set");
  bus_reset_clr_a: assert property (i_bus_reset |=> o_hub_change[1:0] == 2'h0)
    else $error("change flags survive bus reset");
  diag_set_a: assert property (i_req_valid && !i_bus_reset &&
    i_setup == {RT_HUB_SET, RQ_SET_FEATURE, FS_C_LOCAL_POWER, 32'h0} |=> o_hub_change[0])
    else $error("set feature ignored");
  ack_clear_a: assert property (i_req_valid && !lp_chg &&
    i_setup == {RT_HUB_CLR, RQ_CLR_FEATURE, FS_C_LOCAL_POWER, 32'h0} |=> !o_hub_change[0])
    else $error("clear feature ignored");
  flags_hold_a: assert property (!i_req_valid && !i_bus_reset && !lp_chg && !oc_chg
    |=> $stable(o_hub_change)) else $error("change flags moved");
  status_follow_a: assert property ($past(i_rst_n) |->
    o_hub_status[1:0] == {$past(i_hub_over_current), $past(i_local_power_lost)})
    else $error("hub status wrong");
  port_answer_a: assert property (i_req_valid && i_setup.req_type == RT_PORT_STS
    && i_setup.request == RQ_GET_STATUS |=> o_reply.done) else $error("no answer");
  bad_len_a: assert property (i_req_valid && i_setup.req_type == RT_PORT_ERR &&
    i_setup.request == RQ_GET_ERR_CNT && i_setup.length != LEN_ERR_CNT |=> o_reply.req_err)
    else $error("bad length accepted");
  rsvd_zero_a: assert property (o_hub_change[15:2] == 14'h0 && o_hub_status[15:2] == 14'h0)
    else $error("reserved bits set");
endmodule
bind hpsr_status hpsr_status_asserts u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_bus_reset(i_bus_reset), .i_req_valid(i_req_valid), .i_setup(i_setup),
  .o_reply(o_reply), .i_local_power_lost(i_local_power_lost),
  .i_hub_over_current(i_hub_over_current), .o_hub_status(o_hub_status),
  .o_hub_change(o_hub_change));
`default_nettype wire

/* File: tb/hpsr_host_model.sv */
// host model issuing hub class control requests
`timescale 1ns/1ns
`default_nettype none
module hpsr_host_model (
  // clock
  input wire logic i_sys_clk,
  // request
  output logic o_req_valid,
  output var hpsr_pkg::hpsr_setup_t o_setup
);
  import hpsr_pkg::*;
  initial begin
    o_req_valid = 1'b0;
    o_setup = '0;
  end
  // one request; setup inverted once released
  task automatic send(input hpsr_setup_t s);
    @(negedge i_sys_clk);
    o_req_valid = 1'b1;
    o_setup = s;
    @(negedge i_sys_clk);
    o_req_valid = 1'b0;
    o_setup = ~s;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// testbench for the hub port status block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import hpsr_pkg::*;
  logic i_sys_clk, i_rst_n, i_bus_reset, req_valid, lp, oc;
  hpsr_setup_t setup;
  hpsr_reply_t o_reply;
  logic [15:0] o_hub_status, o_hub_change, ls;
  hpsr_dsport_t [3:0] ds;
  logic [3:0] en, poc, rreq, rdone, lerr, ldone;
  logic [63:0] pchg;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  hpsr_host_model host (.i_sys_clk(i_sys_clk), .o_req_valid(req_valid), .o_setup(setup));
  hpsr_status #(.NPORTS(4)) dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_bus_reset(i_bus_reset), .i_req_valid(req_valid), .i_setup(setup), .o_reply(o_reply),
    .i_local_power_lost(lp), .i_hub_over_current(oc), .o_hub_status(o_hub_status),
    .o_hub_change(o_hub_change), .i_ds_state(ds), .i_port_enabled(en),
    .i_port_over_current(poc), .i_port_reset_req(rreq), .i_port_reset_done(rdone),
    .i_link_err(lerr), .i_link_done(ldone), .i_link_state(ls), .i_port_change(pchg));
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles > 5000) begin
      fail_count++;
      end_sim();
    end
  end
  // ==========================================
  // tasks
  task automatic end_sim;
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ask(input logic [7:0] t, input logic [7:0] r, input logic [15:0] v,
      input logic [15:0] p, input logic [15:0] l, input logic [15:0] e0,
      input logic [15:0] e1, input logic er);
    host.send({t, r, v, p, l});
    cmp({15'h0, o_reply.done}, 16'h1);
    cmp({15'h0, o_reply.req_err}, {15'h0, er});
    if (t != RT_HUB_SET) begin
      cmp(o_reply.word0, e0);
      cmp(o_reply.word1, e1);
    end
  endtask
  task automatic pulse(ref logic [3:0] x, input logic [3:0] v);
    @(negedge i_sys_clk);
    x = v;
    @(negedge i_sys_clk);
    x = 4'h0;
  endtask
  task automatic bus_rst;
    @(negedge i_sys_clk);
    i_bus_reset = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    i_bus_reset = 1'b0;
  endtask
  // ==========================================
  // tests
  initial begin
    {i_rst_n, i_bus_reset, lp, oc, en, poc, rreq, rdone, lerr, ldone, ls, pchg} = '0;
    ds = '{default: DS_OTHER};
    repeat (10) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    cmp(o_hub_change, 16'h0000);
    lp = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    cmp(o_hub_status, 16'h0001);
    cmp(o_hub_change, 16'h0001);
    ask(RT_HUB_CLR, RQ_CLR_FEATURE, FS_C_LOCAL_POWER, 0, 0, 0, 0, 0);
    ask(RT_HUB_CLR, RQ_CLR_FEATURE, FS_C_LOCAL_POWER, 0, 0, 0, 0, 0);
    cmp(o_hub_change, 16'h0000);
    oc = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    cmp(o_hub_change, 16'h0002);
    ask(RT_HUB_SET, RQ_SET_FEATURE, FS_C_OVER_CURRENT, 0, 0, 0, 0, 0);
    ask(RT_HUB_SET, RQ_SET_FEATURE, FS_C_LOCAL_POWER, 0, 0, 0, 0, 0);
    cmp(o_hub_change, 16'h0003);
    bus_rst();
    cmp(o_hub_change, 16'h0000);
    cmp(o_hub_status, 16'h0003);
    repeat (3) pulse(lerr, 4'h2);
    ask(RT_PORT_ERR, RQ_GET_ERR_CNT, 0, 2, LEN_ERR_CNT, 16'h3, 0, 0);
    bus_rst();
    ask(RT_PORT_ERR, RQ_GET_ERR_CNT, 0, 2, LEN_ERR_CNT, 0, 0, 0);
    ask(RT_PORT_ERR, RQ_GET_ERR_CNT, 0, 0, LEN_ERR_CNT, 0, 0, 1);
    ask(RT_PORT_ERR, RQ_GET_ERR_CNT, 0, 5, LEN_ERR_CNT, 0, 0, 1);
    ask(RT_PORT_ERR, RQ_GET_ERR_CNT, 1, 2, LEN_ERR_CNT, 0, 0, 1);
    ask(RT_PORT_STS, RQ_GET_STATUS, 0, 2, LEN_ERR_CNT, 0, 0, 1);
    for (int c = 0; c < 12; c++) begin
      ls[3:0] = 4'(c);
      pulse(ldone, 4'h1);
      ask(RT_PORT_STS, RQ_GET_STATUS, 0, 1, LEN_PORT_STS, 16'(c << 5), 0, 0);
    end
    ls[3:0] = 4'h3;
    repeat (2) @(negedge i_sys_clk);
    ask(RT_PORT_STS, RQ_GET_STATUS, 0, 1, LEN_PORT_STS, 16'h0160, 0, 0);
    ls[3:0] = 4'hc;
    pulse(ldone, 4'h1);
    ask(RT_PORT_STS, RQ_GET_STATUS, 0, 1, LEN_PORT_STS, 16'h0160, 0, 0);
    ds[2] = DS_ENABLED;
    {en[2], poc[2], ls[11:8], pchg[47:32]} = {2'h3, 4'h7, 16'h0019};
    pulse(ldone, 4'h4);
    pulse(rreq, 4'h4);
    ask(RT_PORT_STS, RQ_GET_STATUS, 0, 3, LEN_PORT_STS, 16'h00fb, 16'h0019, 0);
    pulse(rdone, 4'h4);
    ds[2] = DS_DISABLED;
    poc[2] = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    ask(RT_PORT_STS, RQ_GET_STATUS, 0, 3, LEN_PORT_STS, 16'h00e0, 16'h0019, 0);
    ds[2] = DS_ERROR;
    repeat (2) @(negedge i_sys_clk);
    ask(RT_PORT_STS, RQ_GET_STATUS, 0, 3, LEN_PORT_STS, 16'h00e3, 16'h0019, 0);
    end_sim();
  end
endmodule
`default_nettype wire
